// ---- pclb_defines.svh ----
// Bit positions, latch codes, lock counts and range limits of the configuration latch bank
`ifndef PCLB_DEFINES_SVH
`define PCLB_DEFINES_SVH
`define PCLB_WORD_W 24
`define PCLB_SEL_CTRL 2'h0
`define PCLB_SEL_FDIV 2'h2
`define PCLB_SEL_RDIV 2'h1
`define PCLB_SEL_TEST 2'h3
// Core control latch fields
`define PCLB_CC_CNT_RST 4
`define PCLB_CC_MUX_LSB 5
`define PCLB_CC_PUMP_3ST 8
`define PCLB_CC_POLARITY 9
`define PCLB_CC_PUMP_GAIN 10
`define PCLB_CC_MUTE 11
`define PCLB_CC_CUR1_LSB 14
`define PCLB_CC_CUR2_LSB 17
`define PCLB_CC_PD_TRIG 20
`define PCLB_CC_PD_SYNC 21
`define PCLB_CC_PRESC_LSB 22
// Feedback divider latch fields
`define PCLB_FD_SWALLOW_LSB 2
`define PCLB_FD_MAIN_LSB 8
`define PCLB_FD_PUMP_GAIN 21
`define PCLB_FD_HALVE 22
`define PCLB_FD_HALVE_SRC 23
// Reference divider latch fields
`define PCLB_RD_RATIO_LSB 2
`define PCLB_RD_PRECISION 18
`define PCLB_RD_TEST_EN 19
`define PCLB_RD_BSC_LSB 20
// Lock qualification counts, sync power-down edge count and main count minimum
`define PCLB_LOCK_CYC_FINE 3'h5
`define PCLB_LOCK_CYC_COARSE 3'h3
`define PCLB_SYNC_PD_EDGES 2'h2
`define PCLB_MAIN_MIN 13'h0003
`endif

// ---- pclb_pkg.sv ----
// Types shared by the configuration latch bank
package pclb_pkg;
  typedef enum logic [1:0] {PCLB_P8, PCLB_P16, PCLB_P32, PCLB_P32B} pclb_presc_t;
  typedef struct packed {
    logic [12:0] main_count;
    logic [4:0] swallow_count;
    logic [1:0] presc_sel;
    logic halve;
    logic halve_src;
  } pclb_fdiv_t;
  typedef struct packed {
    logic pump_3st;
    logic detector_polarity;
    logic [2:0] pump_current;
    logic mute_until_lock;
    logic [2:0] mux_select;
  } pclb_pump_t;
endpackage : pclb_pkg

// ---- pclb_latch_bank.sv ----
// Serial configuration latch bank with power-down sequencing
`timescale 1ns/1ps
`include "pclb_defines.svh"
// Function
// RULE_01: Address bits route word to control, feedback or reference latch.
// RULE_02: Trigger set with sync mode clear powers down at once.
// RULE_03: Both power-down bits set: wait second reference edge after strobe.
// RULE_04: Chip enable low disables device immediately.
// RULE_05: Power-down loads counters, tristates pump, clears lock, mutes outputs.
// RULE_06: Serial input register keeps working during power-down.
// RULE_07: Pump-gain bit picks second current field, else first.
// RULE_08: Pump-gain bit written through either latch, latest write wins.
// RULE_09: Mute-until-lock keeps RF outputs off until lock.
// RULE_10: Pump three-state bit holds charge pump in three-state.
// RULE_11: Polarity bit one gives positive detector polarity.
// RULE_12: Counter-reset bit holds reference and feedback counters reset.
// RULE_13: Swallow counter is five bits, zero through thirty-one.
// RULE_14: Main counter is thirteen bits, three through 8191.
// RULE_15: Total division is prescaler times main plus swallow.
// RULE_16: Output-halving bit divides RF output by two.
// RULE_17: Halving-source bit feeds halved output to prescaler.
// RULE_18: Reference ratio is fourteen bits, one through 16383.
// RULE_19: Lock after five good cycles with precision set, else three.
// RULE_20: Test-enable clear ignores test latch contents.
// RULE_21: Band-select clock from reference output, optionally divided down.
// RULE_22: Host shifts 24 bits; strobe rise transfers word to latch.
// RULE_23: Host programs reference, then control, then feedback latch.
// RULE_24: Address bits are the two least significant bits.
module pclb_latch_bank (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  input wire logic LOAD_STROBE,
  input wire logic CHIP_ENABLE,
  input wire logic REF_DIV_OUT,
  input wire logic PHASE_OK,
  output logic POWERED_DOWN,
  output logic COUNTERS_LOAD,
  output logic LOCKED,
  output logic RF_OUT_EN,
  output logic REF_BUF_EN,
  output logic BAND_CLK,
  output logic PUMP_GAIN,
  output pclb_pkg::pclb_pump_t PUMP_CFG,
  output pclb_pkg::pclb_fdiv_t FDIV_CFG,
  output logic [13:0] REF_RATIO,
  output logic [17:0] TOTAL_DIVIDE,
  output logic MAIN_COUNT_BAD,
  output logic REF_RATIO_BAD
);
  import pclb_pkg::*;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic [3:0] prev_q;
  logic [3:0] raw;
  assign raw = {REF_DIV_OUT, CHIP_ENABLE, LOAD_STROBE, SER_CLK};
  // Two flops per pin; only the second stage and its prev_q copy feed logic
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
      prev_q <= 4'h0;
    end
    else
    begin
      meta_q <= raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  logic data_meta_q;
  logic data_q;
  logic ok_meta_q;
  logic ok_q;
  // Data and phase flag take the same path so they align with the clock pin
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      data_meta_q <= 1'b0;
      data_q <= 1'b0;
      ok_meta_q <= 1'b0;
      ok_q <= 1'b0;
    end
    else
    begin
      data_meta_q <= SER_DATA;
      data_q <= data_meta_q;
      ok_meta_q <= PHASE_OK;
      ok_q <= ok_meta_q;
    end
  end
  logic sclk_rise;
  logic load_rise;
  logic ce_ok;
  logic ref_rise;
  assign sclk_rise = sync_q[0] & ~prev_q[0];
  assign load_rise = sync_q[1] & ~prev_q[1];
  assign ce_ok = sync_q[2];
  assign ref_rise = sync_q[3] & ~prev_q[3];

  // ************************************************************
  // Serial input register
  // ************************************************************
  logic [23:0] shift_q;
  // RULE_06: shifting never gated by power-down
  // RULE_22: one bit per rising serial clock, MSB first
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      shift_q <= 24'h000000;
    else if (sclk_rise)
      shift_q <= {shift_q[22:0], data_q};
  end
  logic [1:0] sel;
  // RULE_24: address in the two lowest bits
  assign sel = {shift_q[1], shift_q[0]};

  // ************************************************************
  // Latches
  // ************************************************************
  logic [23:0] ctrl_q;
  logic [23:0] fdiv_q;
  logic [23:0] rdiv_q;
  logic [23:0] test_q;
  logic gain_q;
  // RULE_01: route word by address on strobe rise
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      ctrl_q <= 24'h000000;
      fdiv_q <= 24'h000000;
      rdiv_q <= 24'h000000;
      test_q <= 24'h000000;
    end
    else if (load_rise)
    begin
      case (sel)
        `PCLB_SEL_CTRL: ctrl_q <= shift_q;
        `PCLB_SEL_FDIV: fdiv_q <= shift_q;
        `PCLB_SEL_RDIV: rdiv_q <= shift_q;
        default: test_q <= shift_q;
      endcase
    end
  end
  // RULE_08: shared pump-gain bit follows latest write via either latch
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      gain_q <= 1'b0;
    else if (load_rise && sel == `PCLB_SEL_CTRL)
      gain_q <= shift_q[`PCLB_CC_PUMP_GAIN];
    else if (load_rise && sel == `PCLB_SEL_FDIV)
      gain_q <= shift_q[`PCLB_FD_PUMP_GAIN];
  end
  // RULE_20: test latch only counts when test enable is set; a nonzero test word then holds LOCKED low
  logic test_active;
  assign test_active = rdiv_q[`PCLB_RD_TEST_EN] & (test_q != 24'h000000);

  // ************************************************************
  // Power-down sequencing
  // ************************************************************
  typedef enum logic [1:0] {PD_RUN, PD_WAIT, PD_DOWN} pclb_pd_state_t;
  pclb_pd_state_t pd_q;
  logic [1:0] edges_q;
  logic pd_trig;
  logic pd_sync;
  logic ctrl_load;
  assign pd_trig = ctrl_q[`PCLB_CC_PD_TRIG];
  assign pd_sync = ctrl_q[`PCLB_CC_PD_SYNC];
  assign ctrl_load = load_rise && sel == `PCLB_SEL_CTRL;
  // Synchronous mode counts reference edges after the strobe so the loop
  // stops at a phase-detector boundary and no frequency jump occurs
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      pd_q <= PD_RUN;
      edges_q <= 2'h0;
    end
    else
    begin
      case (pd_q)
        PD_RUN:
        begin
          edges_q <= 2'h0;
          // RULE_02: asynchronous power-down at once
          if (pd_trig && !pd_sync)
            pd_q <= PD_DOWN;
          // RULE_03: synchronous power-down waits for reference edges
          // The incoming word is read here: the latch itself only updates at this edge
          else if (ctrl_load && shift_q[`PCLB_CC_PD_TRIG] && shift_q[`PCLB_CC_PD_SYNC])
            pd_q <= PD_WAIT;
        end
        PD_WAIT:
        begin
          if (!pd_trig)
            pd_q <= PD_RUN;
          else if (!pd_sync)
            pd_q <= PD_DOWN;
          else if (ref_rise)
          begin
            edges_q <= edges_q + 2'h1;
            if (edges_q + 2'h1 == `PCLB_SYNC_PD_EDGES)
              pd_q <= PD_DOWN;
          end
        end
        PD_DOWN:
        begin
          edges_q <= 2'h0;
          if (!pd_trig)
            pd_q <= PD_RUN;
        end
        default: pd_q <= PD_RUN;
      endcase
    end
  end
  logic down;
  // RULE_04: chip enable low overrides both power-down bits
  assign down = !ce_ok || pd_q == PD_DOWN;

  // ************************************************************
  // Lock detect
  // ************************************************************
  logic [2:0] good_q;
  logic [2:0] need;
  // RULE_19: five good cycles with precision set, three otherwise
  assign need = rdiv_q[`PCLB_RD_PRECISION] ? `PCLB_LOCK_CYC_FINE : `PCLB_LOCK_CYC_COARSE;
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      good_q <= 3'h0;
    // RULE_05: lock detect cleared on power-down
    else if (down || ctrl_q[`PCLB_CC_CNT_RST])
      good_q <= 3'h0;
    else if (ref_rise)
    begin
      if (!ok_q)
        good_q <= 3'h0;
      else if (good_q < need)
        good_q <= good_q + 3'h1;
    end
  end

  // ************************************************************
  // Band-select clock divider
  // ************************************************************
  logic [2:0] bsc_q;
  logic [2:0] bsc_mask;
  // RULE_21: divide reference output by 1, 2, 4 or 8
  always_comb
  begin
    case (rdiv_q[`PCLB_RD_BSC_LSB +: 2])
      2'h0: bsc_mask = 3'h0;
      2'h1: bsc_mask = 3'h1;
      2'h2: bsc_mask = 3'h3;
      default: bsc_mask = 3'h7;
    endcase
  end
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N || down)
      bsc_q <= 3'h0;
    else if (ref_rise)
      bsc_q <= bsc_q + 3'h1;
  end

  // ************************************************************
  // Decoded outputs
  // ************************************************************
  logic [12:0] main_cnt;
  logic [4:0] swallow;
  logic [5:0] modulus;
  // RULE_13: five-bit swallow count, any value valid
  assign swallow = fdiv_q[`PCLB_FD_SWALLOW_LSB +: 5];
  // RULE_14: thirteen-bit main count
  assign main_cnt = fdiv_q[`PCLB_FD_MAIN_LSB +: 13];
  always_comb
  begin
    case (pclb_presc_t'(ctrl_q[`PCLB_CC_PRESC_LSB +: 2]))
      PCLB_P8: modulus = 6'h08;
      PCLB_P16: modulus = 6'h10;
      default: modulus = 6'h20;
    endcase
  end
  // Registered outputs; divider figures are informational for the analog core
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      POWERED_DOWN <= 1'b1;
      COUNTERS_LOAD <= 1'b1;
      LOCKED <= 1'b0;
      RF_OUT_EN <= 1'b0;
      REF_BUF_EN <= 1'b0;
      BAND_CLK <= 1'b0;
      PUMP_GAIN <= 1'b0;
      PUMP_CFG <= '0;
      FDIV_CFG <= '0;
      REF_RATIO <= 14'h0000;
      TOTAL_DIVIDE <= 18'h00000;
      MAIN_COUNT_BAD <= 1'b0;
      REF_RATIO_BAD <= 1'b0;
    end
    else
    begin
      POWERED_DOWN <= down;
      // RULE_05: counters held at load state in power-down
      // RULE_12: counter reset bit holds counters too
      COUNTERS_LOAD <= down | ctrl_q[`PCLB_CC_CNT_RST];
      LOCKED <= !down && good_q >= need && !test_active;
      // RULE_09: outputs stay muted until lock when enabled
      RF_OUT_EN <= !down && (!ctrl_q[`PCLB_CC_MUTE] || LOCKED);
      REF_BUF_EN <= !down;
      BAND_CLK <= (bsc_q & bsc_mask) == 3'h0 && sync_q[3];
      PUMP_GAIN <= gain_q;
      // RULE_10: three-state by bit or power-down
      PUMP_CFG.pump_3st <= down | ctrl_q[`PCLB_CC_PUMP_3ST];
      // RULE_11: one means positive polarity
      PUMP_CFG.detector_polarity <= ctrl_q[`PCLB_CC_POLARITY];
      // RULE_07: gain picks the second or first current field
      PUMP_CFG.pump_current <= gain_q ? ctrl_q[`PCLB_CC_CUR2_LSB +: 3]
                                      : ctrl_q[`PCLB_CC_CUR1_LSB +: 3];
      PUMP_CFG.mute_until_lock <= ctrl_q[`PCLB_CC_MUTE];
      PUMP_CFG.mux_select <= ctrl_q[`PCLB_CC_MUX_LSB +: 3];
      FDIV_CFG.main_count <= main_cnt;
      FDIV_CFG.swallow_count <= swallow;
      FDIV_CFG.presc_sel <= ctrl_q[`PCLB_CC_PRESC_LSB +: 2];
      // RULE_16: output halving
      FDIV_CFG.halve <= fdiv_q[`PCLB_FD_HALVE];
      // RULE_17: halved or fundamental to prescaler
      FDIV_CFG.halve_src <= fdiv_q[`PCLB_FD_HALVE_SRC];
      // RULE_18: fourteen-bit reference ratio, zero flagged
      REF_RATIO <= rdiv_q[`PCLB_RD_RATIO_LSB +: 14];
      REF_RATIO_BAD <= rdiv_q[`PCLB_RD_RATIO_LSB +: 14] == 14'h0000;
      MAIN_COUNT_BAD <= main_cnt < `PCLB_MAIN_MIN;
      // RULE_15: modulus times main plus swallow
      // Largest product plus swallow fills all 18 bits exactly
      TOTAL_DIVIDE <= 18'(modulus) * 18'(main_cnt) + 18'(swallow);
    end
  end
endmodule : pclb_latch_bank

// ---- pclb_host.sv ----
// Host model that shifts configuration words into the latch bank
`timescale 1ns/1ps
module pclb_host (
  input wire logic clk,
  output logic ser_clk,
  output logic ser_data,
  output logic load_strobe
);
  // Serial clock parks low between frames
  initial
  begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b0;
  end
  // 24 bits, MSB first, then strobe
  // Each phase lasts 4 cycles because the pins pass a 2-flop synchroniser
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--)
    begin
      @(posedge clk) ser_data <= w[i];
      repeat (4) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge clk);
      ser_clk <= 1'b0;
    end
    // Stale data is flipped so a late sample cannot pass as valid
    @(posedge clk) ser_data <= ~w[0];
    load_strobe <= 1'b1;
    repeat (4) @(posedge clk);
    load_strobe <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : send
endmodule : pclb_host

// ---- pclb_latch_bank_checker.sv ----
// Port checker for the configuration latch bank
`timescale 1ns/1ps
module pclb_latch_bank_checker (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CHIP_ENABLE,
  input wire logic POWERED_DOWN,
  input wire logic COUNTERS_LOAD,
  input wire logic LOCKED,
  input wire logic RF_OUT_EN,
  input wire logic REF_BUF_EN,
  input pclb_pkg::pclb_pump_t PUMP_CFG,
  input pclb_pkg::pclb_fdiv_t FDIV_CFG,
  input wire logic [13:0] REF_RATIO,
  input wire logic [17:0] TOTAL_DIVIDE,
  input wire logic MAIN_COUNT_BAD,
  input wire logic REF_RATIO_BAD
);
  import pclb_pkg::*;
  default clocking dc @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  // Prescaler code 0 is 8, 1 is 16, the rest 32
  function automatic logic [17:0] exp_div(input pclb_fdiv_t f);
    logic [17:0] p;
    p = (f.presc_sel == 2'h0) ? 18'h8 : ((f.presc_sel == 2'h1) ? 18'h10 : 18'h20);
    return p * f.main_count + f.swallow_count;
  endfunction : exp_div
  // ****
  // Power state
  // ****
  a_pd_load: assert property (POWERED_DOWN [*2] |-> COUNTERS_LOAD)
    else $error("counters not loaded in power-down");
  a_pd_outputs: assert property (POWERED_DOWN [*2] |-> !RF_OUT_EN && !REF_BUF_EN && !LOCKED)
    else $error("outputs active in power-down");
  a_ce_off: assert property (!CHIP_ENABLE [*6] |-> POWERED_DOWN)
    else $error("chip enable low but running");
  a_buf_running: assert property (!POWERED_DOWN [*2] |-> REF_BUF_EN)
    else $error("reference buffer off while running");
  a_mute_hold: assert property ((PUMP_CFG.mute_until_lock && !LOCKED) [*2] |-> !RF_OUT_EN)
    else $error("output on before lock while muted");
  // ****
  // Divider figures
  // ****
  a_div_total: assert property ($stable(FDIV_CFG) [*2] |-> TOTAL_DIVIDE == exp_div(FDIV_CFG))
    else $error("total division wrong");
  a_main_range: assert property ($changed(FDIV_CFG.main_count) ##1 $stable(FDIV_CFG.main_count) |->
    MAIN_COUNT_BAD == (FDIV_CFG.main_count < 13'h0003))
    else $error("main count range flag wrong");
  a_ratio_range: assert property ($changed(REF_RATIO) ##1 $stable(REF_RATIO) |->
    REF_RATIO_BAD == (REF_RATIO == 14'h0000))
    else $error("reference ratio range flag wrong");
  c_pd_enter: cover property ($rose(POWERED_DOWN));
  c_lock: cover property ($rose(LOCKED));
  c_main_bad: cover property (MAIN_COUNT_BAD);
endmodule : pclb_latch_bank_checker
bind pclb_latch_bank pclb_latch_bank_checker chk_u (.CLK_SYS, .RST_N, .CHIP_ENABLE,
  .POWERED_DOWN, .COUNTERS_LOAD, .LOCKED, .RF_OUT_EN, .REF_BUF_EN, .PUMP_CFG, .FDIV_CFG,
  .REF_RATIO, .TOTAL_DIVIDE, .MAIN_COUNT_BAD, .REF_RATIO_BAD);

// ---- pclb_latch_bank_test.sv ----
// Self-checking bench for the configuration latch bank
`timescale 1ns/1ps
module pclb_latch_bank_test;
  import pclb_pkg::*;
  `define CHK(nm, ex, gt) \
    begin check_count++; if ((gt) !== (ex)) begin n_fail++; \
    $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
  logic clk, ser_clk, ser_data, load_strobe, pd, cnt_load, locked, rf_en, ref_buf, gain;
  logic rst_n = 1'b0, ce = 1'b1, ref_out = 1'b0, phase_ok = 1'b0;
  logic band_clk;
  pclb_pump_t pump;
  pclb_fdiv_t fdiv;
  logic [13:0] ratio;
  // Shadow of the three latches and the shared gain bit
  logic [23:0] cc = 24'h0, fd = 24'h0, rd = 24'h0;
  logic g = 1'b0;
  int n_fail = 0;
  int check_count = 0;
  // Ordinary cases: {expected gain, word}
  // first rows program reference, then control, then feedback
  logic [24:0] rows [14] = '{25'h0000015, 25'h04ac240, 25'h160037e, 25'h14ac640,
    25'h09fff02, 25'h0ffffff, 25'h000fffd, 25'h0000202, 25'h0000001, 25'h08ac240,
    25'h0cac240, 25'h00ac240, 25'h0000015, 25'h000037e};
  pclb_host host_u (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data),
    .load_strobe(load_strobe));
  pclb_latch_bank dut_u (.CLK_SYS(clk), .RST_N(rst_n), .SER_CLK(ser_clk),
    .SER_DATA(ser_data), .LOAD_STROBE(load_strobe), .CHIP_ENABLE(ce),
    .REF_DIV_OUT(ref_out), .PHASE_OK(phase_ok), .POWERED_DOWN(pd), .COUNTERS_LOAD(cnt_load),
    .LOCKED(locked), .RF_OUT_EN(rf_en), .REF_BUF_EN(ref_buf), .BAND_CLK(band_clk),
    .PUMP_GAIN(gain),
    .PUMP_CFG(pump), .FDIV_CFG(fdiv), .REF_RATIO(ratio), .TOTAL_DIVIDE(),
    .MAIN_COUNT_BAD(), .REF_RATIO_BAD());
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Write a word and track it; the test latch (code 3) is not shadowed, it can only hold LOCKED low
  task automatic wr(input logic [23:0] w);
    host_u.send(w);
    if (w[1:0] == 2'h0) {cc, g} = {w, w[10]};
    else if (w[1:0] == 2'h2) {fd, g} = {w, w[21]};
    else if (w[1:0] == 2'h1) rd = w;
  endtask : wr
  // Power-down forces the pump into three-state whatever the latch bit says
  task automatic check_cfg(input logic off);
    `CHK("pump_cfg", ({cc[8] | off, cc[9], g ? cc[19:17] : cc[16:14], cc[11], cc[7:5]}), pump)
    `CHK("fdiv_cfg", ({fd[20:8], fd[6:2], cc[23:22], fd[22], fd[23]}), fdiv)
    `CHK("ref_ratio", rd[15:2], ratio)
    `CHK("pump_gain", g, gain)
  endtask : check_cfg
  // Reference divider pulses, long enough to cross the synchroniser
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clk) ref_out <= 1'b1;
      repeat (8) @(posedge clk);
      ref_out <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask : pulse
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  // Hang guard
  initial
  begin
    #300us;
    n_fail++;
    give_verdict();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    `CHK("reset_pd", 1'b1, pd)
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("reset_left", 1'b0, pd)
    $display("reset test done");
    foreach (rows[i])
    begin
      wr(rows[i][23:0]);
      `CHK("row_gain", rows[i][24], gain)
      check_cfg(1'b0);
    end
    $display("table test done");
    wr(24'h0ac250);
    `CHK("cnt_hold", 1'b1, cnt_load)
    wr(24'h0aca40);
    `CHK("cnt_free", 1'b0, cnt_load)
    `CHK("muted", 1'b0, rf_en)
    phase_ok <= 1'b1;
    pulse(3);
    `CHK("lock_coarse", 1'b1, locked)
    `CHK("unmuted", 1'b1, rf_en)
    $display("lock test done");
    wr(24'h1aca40);
    `CHK("pd_async", 1'b1, pd)
    `CHK("pd_counters", 1'b1, cnt_load)
    `CHK("pd_lock", 1'b0, locked)
    `CHK("pd_rf", 1'b0, rf_en)
    `CHK("pd_refbuf", 1'b0, ref_buf)
    wr(24'h040015);
    check_cfg(1'b1);
    wr(24'h0aca40);
    `CHK("pd_left", 1'b0, pd)
    pulse(3);
    `CHK("lock_fine_early", 1'b0, locked)
    pulse(2);
    `CHK("lock_fine", 1'b1, locked)
    // Band-select divider is off here, so the band clock follows the reference
    ref_out <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK("band_clk", 1'b1, band_clk)
    ref_out <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK("band_idle", 1'b0, band_clk)
    $display("async power-down test done");
    wr(24'h3aca40);
    `CHK("sync_wait", 1'b0, pd)
    pulse(1);
    `CHK("sync_one", 1'b0, pd)
    pulse(1);
    `CHK("sync_two", 1'b1, pd)
    wr(24'h0aca40);
    $display("sync power-down test done");
    ce <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("ce_low", 1'b1, pd)
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("ce_high", 1'b0, pd)
    $display("chip enable test done");
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    {cc, fd, rd, g} = '0;
    check_cfg(1'b0);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("reset_again_left", 1'b0, pd)
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule : pclb_latch_bank_test
